// File: logic/pwe_pkg.sv
// Package with offsets, fields and reset values of the window enable and I/O control bank
// Behaviour
// - After reset all memory and I/O windows are disabled; enable register reads 00h.
// - A window whose enable bit is 0b never claims a host cycle.
// - Enable bit 7 turns on I/O window 1, bit 6 turns on I/O window 0.
// - Enable bits 4 to 0 turn on memory windows 4 to 0.
// - Enable bit 5 is reserved: reads zero, writes ignored.
// - Wide-extra-wait bit (7 or 3) adds one ISA wait to 16-bit cycles only.
// - Narrow-fast bit (6 or 2) shortens 8-bit cycles to three ISA cycles only.
// - Auto-size bit (5 or 1) takes width from card IOIS16, else from size bit.
// - Size bit (4 or 0): 0 is 8-bit, 1 is 16-bit; ignored under auto-size.
// - I/O window control register resets to 00h.
// - Start address low bytes at 08h and 0Ch, reset zero.
// - Start address high bytes at 09h and 0Dh, reset zero.
// - End address low bytes at 0Ah and 0Eh, with start they bound the window.
package pwe_pkg;
  localparam logic [7:0] OFS_WINDOW_ENABLE = 8'h06;
  localparam logic [7:0] OFS_IO_WINDOW_CONTROL = 8'h07;
  localparam logic [7:0] OFS_IO_WIN0_START_LOW = 8'h08;
  localparam logic [7:0] OFS_IO_WIN0_START_HIGH = 8'h09;
  localparam logic [7:0] OFS_IO_WIN0_END_LOW = 8'h0A;
  localparam logic [7:0] OFS_IO_WIN0_END_HIGH = 8'h0B;
  localparam logic [7:0] OFS_IO_WIN1_START_LOW = 8'h0C;
  localparam logic [7:0] OFS_IO_WIN1_START_HIGH = 8'h0D;
  localparam logic [7:0] OFS_IO_WIN1_END_LOW = 8'h0E;
  localparam logic [7:0] OFS_IO_WIN1_END_HIGH = 8'h0F;
  localparam logic [7:0] WINDOW_ENABLE_RESET = 8'h00;
  localparam logic [7:0] WINDOW_ENABLE_WMASK = 8'hDF;
  localparam logic [7:0] IO_WINDOW_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDR_BYTE_RESET = 8'h00;
  localparam int unsigned EN_IO_WIN0_BIT = 6;
  localparam int unsigned NUM_MEM_WIN = 5;
  // Per I/O window field positions inside the control register: window n uses base 4*n
  localparam int unsigned CTL_WIDTH_SEL_BIT = 0;
  localparam int unsigned CTL_AUTO_SIZE_BIT = 1;
  localparam int unsigned CTL_NARROW_FAST_BIT = 2;
  localparam int unsigned CTL_WIDE_EXTRA_WAIT_BIT = 3;
  localparam int unsigned CTL_WIN_STRIDE = 4;
endpackage : pwe_pkg

// File: logic/pwe_regs.sv
// Window enable, I/O window control and I/O window address registers with cycle claim
`timescale 1ns/1ns
module pwe_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Socket register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Host cycle request
  input wire logic host_io_req,
  input wire logic [15:0] host_io_addr,
  input wire logic host_mem_req,
  input wire logic [pwe_pkg::NUM_MEM_WIN-1:0] host_mem_hit,
  // Card pin
  input wire logic card_iois16,
  // Cycle decision
  output logic io_claim,
  output logic [1:0] io_claim_win,
  output logic io_cycle_wide,
  output logic io_extra_wait,
  output logic io_narrow_fast,
  output logic mem_claim,
  output logic [pwe_pkg::NUM_MEM_WIN-1:0] mem_claim_win,
  // Window enables
  output logic io_win1_on,
  output logic io_win0_on,
  output logic [pwe_pkg::NUM_MEM_WIN-1:0] mem_win_on
);
  import pwe_pkg::*;

  logic [7:0] window_enable;
  logic [7:0] next_window_enable;
  logic [7:0] io_window_control;
  logic [7:0] next_io_window_control;
  logic [7:0] start_lo [2];
  logic [7:0] next_start_lo [2];
  logic [7:0] start_hi [2];
  logic [7:0] next_start_hi [2];
  logic [7:0] end_lo [2];
  logic [7:0] next_end_lo [2];
  logic [7:0] end_hi [2];
  logic [7:0] next_end_hi [2];
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic iois16_meta;
  logic iois16_sync;
  logic next_io_claim;
  logic [1:0] next_io_claim_win;
  logic next_io_cycle_wide;
  logic next_io_extra_wait;
  logic next_io_narrow_fast;
  logic next_mem_claim;
  logic [NUM_MEM_WIN-1:0] next_mem_claim_win;
  logic [1:0] io_hit;

  // Picks one field of the I/O control register for window 0 or 1
  function automatic logic ctl_field(input logic [7:0] ctl, input logic win1, input int unsigned pos);
    logic [2:0] idx;
    idx = 3'(pos) + (win1 ? 3'(CTL_WIN_STRIDE) : 3'd0);
    return ctl[idx];
  endfunction : ctl_field

  // Register file
  always_comb begin
    next_window_enable = window_enable;
    next_io_window_control = io_window_control;
    next_start_lo = start_lo;
    next_start_hi = start_hi;
    next_end_lo = end_lo;
    next_end_hi = end_hi;
    if (reg_wr) begin
      case (reg_addr)
        OFS_WINDOW_ENABLE: next_window_enable = reg_wdata & WINDOW_ENABLE_WMASK;
        OFS_IO_WINDOW_CONTROL: next_io_window_control = reg_wdata;
        OFS_IO_WIN0_START_LOW: next_start_lo[0] = reg_wdata;
        OFS_IO_WIN0_START_HIGH: next_start_hi[0] = reg_wdata;
        OFS_IO_WIN0_END_LOW: next_end_lo[0] = reg_wdata;
        OFS_IO_WIN0_END_HIGH: next_end_hi[0] = reg_wdata;
        OFS_IO_WIN1_START_LOW: next_start_lo[1] = reg_wdata;
        OFS_IO_WIN1_START_HIGH: next_start_hi[1] = reg_wdata;
        OFS_IO_WIN1_END_LOW: next_end_lo[1] = reg_wdata;
        OFS_IO_WIN1_END_HIGH: next_end_hi[1] = reg_wdata;
        default: ;
      endcase
    end
  end

  // Read port; unmapped offsets answer 00h
  always_comb begin
    next_reg_rdata = 8'h00;
    next_reg_rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        OFS_WINDOW_ENABLE: next_reg_rdata = window_enable & WINDOW_ENABLE_WMASK;
        OFS_IO_WINDOW_CONTROL: next_reg_rdata = io_window_control;
        OFS_IO_WIN0_START_LOW: next_reg_rdata = start_lo[0];
        OFS_IO_WIN0_START_HIGH: next_reg_rdata = start_hi[0];
        OFS_IO_WIN0_END_LOW: next_reg_rdata = end_lo[0];
        OFS_IO_WIN0_END_HIGH: next_reg_rdata = end_hi[0];
        OFS_IO_WIN1_START_LOW: next_reg_rdata = start_lo[1];
        OFS_IO_WIN1_START_HIGH: next_reg_rdata = start_hi[1];
        OFS_IO_WIN1_END_LOW: next_reg_rdata = end_lo[1];
        OFS_IO_WIN1_END_HIGH: next_reg_rdata = end_hi[1];
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      window_enable <= WINDOW_ENABLE_RESET;
      io_window_control <= IO_WINDOW_CONTROL_RESET;
      for (int i = 0; i < 2; i++) begin
        start_lo[i] <= ADDR_BYTE_RESET;
        start_hi[i] <= ADDR_BYTE_RESET;
        end_lo[i] <= ADDR_BYTE_RESET;
        end_hi[i] <= ADDR_BYTE_RESET;
      end
    end else begin
      window_enable <= next_window_enable;
      io_window_control <= next_io_window_control;
      start_lo <= next_start_lo;
      start_hi <= next_start_hi;
      end_lo <= next_end_lo;
      end_hi <= next_end_hi;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // Card width pin synchroniser
  // Pin is asynchronous to the host clock; only the second stage feeds the decode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      iois16_meta <= 1'b0;
      iois16_sync <= 1'b0;
    end else begin
      iois16_meta <= card_iois16;
      iois16_sync <= iois16_meta;
    end
  end

  // Window range match, enable gated
  generate
    for (genvar w = 0; w < 2; w++) begin : g_io_hit
      assign io_hit[w] = window_enable[EN_IO_WIN0_BIT + w]
        && host_io_addr >= {start_hi[w], start_lo[w]}
        && host_io_addr <= {end_hi[w], end_lo[w]};
    end
  endgenerate

  // Cycle decision; window 0 wins if both match
  always_comb begin
    logic win1;
    logic wide;
    win1 = 1'b0;
    wide = 1'b0;
    next_io_claim = 1'b0;
    next_io_claim_win = 2'b00;
    next_io_cycle_wide = 1'b0;
    next_io_extra_wait = 1'b0;
    next_io_narrow_fast = 1'b0;
    if (host_io_req && io_hit != 2'b00) begin
      next_io_claim = 1'b1;
      next_io_claim_win = io_hit[0] ? 2'b01 : 2'b10;
      win1 = !io_hit[0];
      wide = ctl_field(io_window_control, win1, CTL_AUTO_SIZE_BIT) ? iois16_sync
        : ctl_field(io_window_control, win1, CTL_WIDTH_SEL_BIT);
      next_io_cycle_wide = wide;
      next_io_extra_wait = wide && ctl_field(io_window_control, win1, CTL_WIDE_EXTRA_WAIT_BIT);
      next_io_narrow_fast = !wide && ctl_field(io_window_control, win1, CTL_NARROW_FAST_BIT);
    end
  end

  // Memory claim; address match is done outside, enables gate it here
  always_comb begin
    next_mem_claim_win = host_mem_req ? (host_mem_hit & window_enable[NUM_MEM_WIN-1:0]) : '0;
    next_mem_claim = |next_mem_claim_win;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_claim <= 1'b0;
      io_claim_win <= 2'b00;
      io_cycle_wide <= 1'b0;
      io_extra_wait <= 1'b0;
      io_narrow_fast <= 1'b0;
    end else begin
      io_claim <= next_io_claim;
      io_claim_win <= next_io_claim_win;
      io_cycle_wide <= next_io_cycle_wide;
      io_extra_wait <= next_io_extra_wait;
      io_narrow_fast <= next_io_narrow_fast;
    end
  end

  // Enable copies load from the next value so they never lag the register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_claim <= 1'b0;
      mem_claim_win <= '0;
      io_win1_on <= 1'b0;
      io_win0_on <= 1'b0;
      mem_win_on <= '0;
    end else begin
      mem_claim <= next_mem_claim;
      mem_claim_win <= next_mem_claim_win;
      io_win1_on <= next_window_enable[EN_IO_WIN0_BIT + 1];
      io_win0_on <= next_window_enable[EN_IO_WIN0_BIT];
      mem_win_on <= next_window_enable[NUM_MEM_WIN-1:0];
    end
  end
endmodule : pwe_regs

// File: tb/pwe_card_model.sv
// Card model driving the 16-bit select pin
`timescale 1ns/1ns
module pwe_card_model (
  // Clock and command
  input wire logic clk_sys,
  input wire logic wide_mode,
  // Card pin
  output logic card_iois16
);
  initial begin
    card_iois16 = 1'b0;
    forever @(posedge clk_sys) card_iois16 <= #1 wide_mode;
  end
endmodule : pwe_card_model

// File: tb/pwe_regs_chk.sv
// Port checker for the window enable and I/O control bank
`timescale 1ns/1ns
module pwe_regs_chk (
  // Clock, reset, register port
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Requests and decisions
  input wire logic host_io_req,
  input wire logic host_mem_req,
  input wire logic [pwe_pkg::NUM_MEM_WIN-1:0] host_mem_hit,
  input wire logic io_claim,
  input wire logic [1:0] io_claim_win,
  input wire logic io_cycle_wide,
  input wire logic io_extra_wait,
  input wire logic io_narrow_fast,
  input wire logic mem_claim,
  input wire logic [pwe_pkg::NUM_MEM_WIN-1:0] mem_claim_win,
  input wire logic io_win1_on,
  input wire logic io_win0_on,
  input wire logic [pwe_pkg::NUM_MEM_WIN-1:0] mem_win_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  a_read_answer: assert property (reg_rd |-> s_read) else $error("read not answered");
  a_idle_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00 && !reg_rvalid) else $error("idle data");
  a_rsvd_zero: assert property (reg_rd && reg_addr == pwe_pkg::OFS_WINDOW_ENABLE |=> !reg_rdata[5])
    else $error("bit 5 set");
  a_io_no_req: assert property (!host_io_req |=> !io_claim) else $error("claim without request");
  a_win0_gate: assert property (io_claim_win[0] |-> $past(io_win0_on)) else $error("win0 off");
  a_win1_gate: assert property (io_claim_win[1] |-> $past(io_win1_on)) else $error("win1 off");
  a_claim_onehot: assert property (io_claim == (|io_claim_win) && $onehot0(io_claim_win)) else $error("win code");
  a_mem_mask: assert property (host_mem_req |=> mem_claim_win == ($past(host_mem_hit) & $past(mem_win_on)))
    else $error("mem mask");
  a_mem_any: assert property (mem_claim == (|mem_claim_win)) else $error("mem claim");
  a_wait_wide: assert property (io_extra_wait |-> io_cycle_wide) else $error("wait on narrow");
  a_fast_narrow: assert property (io_narrow_fast |-> !io_cycle_wide) else $error("fast on wide");
endmodule : pwe_regs_chk

// File: tb/pwe_regs_tb.sv
// Self-checking testbench for the window enable and I/O control bank
`timescale 1ns/1ns
module pwe_regs_tb;
  import pwe_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, host_io_req, host_mem_req, card_iois16, wide_mode;
  logic io_claim, io_cycle_wide, io_extra_wait, io_narrow_fast, mem_claim, io_win1_on, io_win0_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] host_io_addr;
  logic [1:0] io_claim_win;
  logic [NUM_MEM_WIN-1:0] host_mem_hit, mem_claim_win, mem_win_on;
  int error_cnt = 0, checked = 0, cycles = 0;
  pwe_regs i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .host_io_req(host_io_req),
    .host_io_addr(host_io_addr), .host_mem_req(host_mem_req), .host_mem_hit(host_mem_hit),
    .card_iois16(card_iois16), .io_claim(io_claim), .io_claim_win(io_claim_win), .io_cycle_wide(io_cycle_wide),
    .io_extra_wait(io_extra_wait), .io_narrow_fast(io_narrow_fast), .mem_claim(mem_claim),
    .mem_claim_win(mem_claim_win), .io_win1_on(io_win1_on), .io_win0_on(io_win0_on), .mem_win_on(mem_win_on)
  );
  pwe_card_model i_card (.clk_sys(clk_sys), .wide_mode(wide_mode), .card_iois16(card_iois16));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys) #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [8:0] v);
    @(posedge clk_sys) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys) #1 reg_rd = 1'b0;
    v = {reg_rvalid, reg_rdata};
  endtask : rd
  task automatic io(input logic [15:0] a, output logic [5:0] r);
    @(posedge clk_sys) #1 {host_io_req, host_io_addr} = {1'b1, a};
    @(posedge clk_sys) #1 host_io_req = 1'b0;
    r = {io_claim, io_claim_win, io_cycle_wide, io_extra_wait, io_narrow_fast};
  endtask : io
  task automatic mem(input logic [4:0] h, output logic [5:0] m);
    @(posedge clk_sys) #1 {host_mem_req, host_mem_hit} = {1'b1, h};
    @(posedge clk_sys) #1 host_mem_req = 1'b0;
    m = {mem_claim, mem_claim_win};
  endtask : mem
  task automatic t_reset;
    logic [8:0] v;
    chk({io_win1_on, io_win0_on, mem_win_on, io_claim, mem_claim}, 16'h0000);
    for (int a = 6; a <= 16; a++) begin
      rd(a[7:0], v);
      chk(v, 16'h0100);
    end
    $display("t_reset done");
  endtask : t_reset
  task automatic t_enable;
    logic [8:0] v;
    logic [7:0] e;
    logic [5:0] m;
    for (int i = 0; i < 8; i++) begin
      e = 8'h01 << i & WINDOW_ENABLE_WMASK;
      wr(OFS_WINDOW_ENABLE, 8'h01 << i);
      rd(OFS_WINDOW_ENABLE, v);
      chk(v, {1'b1, e});
      chk({io_win1_on, io_win0_on, mem_win_on}, {e[7:6], e[4:0]});
      mem(5'h1F, m);
      chk(m, {|e[4:0], e[4:0]});
    end
    $display("t_enable done");
  endtask : t_enable
  task automatic t_io;
    logic [15:0] ta [6] = '{16'h010F, 16'h0110, 16'h01FF, 16'h0200, 16'h0305, 16'h0305};
    logic [5:0] te [6] = '{6'h00, 6'h2E, 6'h2E, 6'h00, 6'h31, 6'h34};
    logic [8:0] v;
    logic [5:0] r;
    wr(OFS_IO_WIN0_START_LOW, 8'h10);
    wr(OFS_IO_WIN0_START_HIGH, 8'h01);
    wr(OFS_IO_WIN0_END_LOW, 8'hFF);
    wr(OFS_IO_WIN0_END_HIGH, 8'h01);
    wr(OFS_IO_WIN1_START_LOW, 8'h05);
    wr(OFS_IO_WIN1_START_HIGH, 8'h03);
    wr(OFS_IO_WIN1_END_LOW, 8'h05);
    wr(OFS_IO_WIN1_END_HIGH, 8'h03);
    rd(OFS_IO_WIN1_START_LOW, v);
    chk(v, 16'h0105);
    rd(OFS_IO_WIN1_START_HIGH, v);
    chk(v, 16'h0103);
    wr(OFS_WINDOW_ENABLE, 8'h00);
    io(16'h0110, r);
    chk(r, 16'h0000);
    wr(OFS_WINDOW_ENABLE, 8'hC0);
    wr(OFS_IO_WINDOW_CONTROL, 8'h79);
    for (int i = 0; i < 6; i++) begin
      wide_mode = (i == 5);
      repeat (4) @(posedge clk_sys);
      io(ta[i], r);
      chk(r, te[i]);
    end
    wr(OFS_IO_WINDOW_CONTROL, 8'h0C);
    io(16'h0110, r);
    chk(r, 16'h0029);
    $display("t_io done");
  endtask : t_io
  initial begin
    {reg_wr, reg_rd, host_io_req, host_mem_req, wide_mode, rst_n} = '0;
    {reg_addr, reg_wdata, host_io_addr, host_mem_hit} = '0;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset;
    t_enable;
    t_io;
    tally_and_finish;
  end
endmodule : pwe_regs_tb
bind pwe_regs pwe_regs_chk i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .host_io_req(host_io_req), .host_mem_req(host_mem_req), .host_mem_hit(host_mem_hit),
  .io_claim(io_claim), .io_claim_win(io_claim_win), .io_cycle_wide(io_cycle_wide), .io_extra_wait(io_extra_wait),
  .io_narrow_fast(io_narrow_fast), .mem_claim(mem_claim), .mem_claim_win(mem_claim_win),
  .io_win1_on(io_win1_on), .io_win0_on(io_win0_on), .mem_win_on(mem_win_on)
);
